// file: verilog/opvc_ctrl.sv
// Programmer that drives the array's pins to program and verify it
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Code 296H, strobe pulsed, high voltage: program user array.
// - Code 296H, strobe and voltage pin high: verify user array.
// - Code 292H, strobe pulsed, high voltage: program key array.
// - Code 292H, strobe and voltage pin high: verify key array.
// - Code 29AH, pulsed, high voltage: program security bit 1.
// - Code 298H, pulsed, high voltage: program security bit 2.
// - Code 29AH, strobe and voltage pin high: read security bits.
// - Address valid 10us plus 24 periods before strobe falls.
// - Address held 48 periods after strobe rises.
// - Data set 38 periods before strobe falls, held 36 after.
// - High voltage 10us before first strobe, 10us after last.
// - Strobe low 90 to 110us; at least 10us high between.
// - High address 13 periods before select falls, held 2 after.
// - Sync pulse low at least 4 periods, high at least 8.
// - 10-bit code on reset pin, LSB first, one bit per clock.
// - Address select high at least 13 clocks for high byte.
// - 25 strobe pulses per cycle, strobe left high after.
module opvc_ctrl #(
  parameter int OSC_DIV = opvc_pkg::OSC_DIV_DEF,
  parameter int PULSE_CYC = opvc_pkg::T_PULSE_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire opvc_pkg::opvc_cmd_t cmd,
  output logic rsp_valid,
  output opvc_pkg::opvc_rsp_t rsp,
  output logic osc_clk,
  output logic device_reset_pin,
  output logic sync_pulse_pin,
  output logic program_strobe_n,
  output logic vpp_high,
  output logic address_byte_select,
  output logic [7:0] addr_port,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe
);
  import opvc_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] osc_cyc(input int n);
    return 16'(n * OSC_DIV);
  endfunction : osc_cyc

  function automatic logic mode_known(input logic [2:0] op);
    return op <= OP_VER_SEC;
  endfunction : mode_known

  function automatic logic [9:0] mode_code(input logic [2:0] op);
    case (op)
      OP_PROGRAM_PULSE_N_USER, OP_VER_USER: return CODE_USER;
      OP_PROGRAM_PULSE_N_KEY, OP_VER_KEY: return CODE_KEY;
      OP_PROGRAM_PULSE_N_SEC1, OP_VER_SEC: return CODE_SEC1;
      OP_PROGRAM_PULSE_N_SEC2: return CODE_SEC2;
      default: return CODE_USER;
    endcase
  endfunction : mode_code

  typedef enum logic [13:0] {
    S_IDLE = 14'h0001,
    S_RST = 14'h0002,
    S_SYNC_L = 14'h0004,
    S_SYNC_H = 14'h0008,
    S_SHIFT = 14'h0010,
    S_AHI = 14'h0020,
    S_AHOLD = 14'h0040,
    S_ALO = 14'h0080,
    S_VPPUP = 14'h0100,
    S_PLOW = 14'h0200,
    S_PHIGH = 14'h0400,
    S_VPPHOLD = 14'h0800,
    S_VERIFY = 14'h1000,
    S_DONE = 14'h2000
  } opvc_state_t;

  localparam int HALF = OSC_DIV / 2;
  localparam logic [15:0] DIV_LAST = 16'(OSC_DIV - 1);
  localparam logic [15:0] DIV_HALF = 16'(HALF - 1);

  opvc_state_t state;
  opvc_state_t next_state;
  logic [15:0] timer;
  logic [15:0] next_timer;
  logic [15:0] div_cnt;
  logic [3:0] bit_cnt;
  logic [4:0] pulse_cnt;
  opvc_cmd_t job;
  logic is_program_pulse_n;
  logic is_sec;
  logic fall_tick;

  assign is_program_pulse_n = (job.op == OP_PROGRAM_PULSE_N_USER) || (job.op == OP_PROGRAM_PULSE_N_KEY) ||
                   (job.op == OP_PROGRAM_PULSE_N_SEC1) || (job.op == OP_PROGRAM_PULSE_N_SEC2);
  assign is_sec = (job.op == OP_PROGRAM_PULSE_N_SEC1) || (job.op == OP_PROGRAM_PULSE_N_SEC2) ||
                  (job.op == OP_VER_SEC);
  assign cmd_ready = (state == S_IDLE);
  assign fall_tick = (div_cnt == DIV_HALF);

  // ------------------------------------------------------------
  // Oscillator for the device
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      div_cnt <= 16'h0000;
      osc_clk <= 1'b1;
    end else begin
      div_cnt <= (div_cnt == DIV_LAST) ? 16'h0000 : div_cnt + 16'h0001;
      if (div_cnt == DIV_LAST) begin
        osc_clk <= 1'b1;
      end else if (fall_tick) begin
        osc_clk <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_timer = (timer != 16'h0000) ? timer - 16'h0001 : timer;
    case (state)
      S_IDLE: begin
        if (cmd_valid && mode_known(cmd.op)) begin
          next_state = S_RST;
          next_timer = osc_cyc(T_RST_OSC);
        end
      end
      S_RST: begin
        if (timer == 16'h0000) begin
          next_state = S_SYNC_L;
          next_timer = osc_cyc(T_SYNC_L_OSC);
        end
      end
      S_SYNC_L: begin
        if (timer == 16'h0000) begin
          next_state = S_SYNC_H;
          next_timer = osc_cyc(T_SYNC_H_OSC);
        end
      end
      S_SYNC_H: begin
        if (timer == 16'h0000) begin
          next_state = S_SHIFT;
        end
      end
      S_SHIFT: begin
        if (fall_tick && bit_cnt == 4'(CODE_BITS)) begin
          if (!is_sec) begin
            next_state = S_AHI;
            next_timer = osc_cyc(T_SEL_HI_OSC);
          end else if (is_program_pulse_n) begin
            next_state = S_VPPUP;
            next_timer = 16'(T_VPP_SETUP_CYC);
          end else begin
            next_state = S_VERIFY;
            next_timer = osc_cyc(T_VER_PURE_OSC);
          end
        end
      end
      S_AHI: begin
        if (timer == 16'h0000) begin
          next_state = S_AHOLD;
          next_timer = osc_cyc(T_AHOLD_OSC);
        end
      end
      S_AHOLD: begin
        if (timer == 16'h0000) begin
          next_state = S_ALO;
          next_timer = osc_cyc(T_ALO_OSC + T_ADDR_VPP_OSC);
        end
      end
      S_ALO: begin
        if (timer == 16'h0000) begin
          if (is_program_pulse_n) begin
            next_state = S_VPPUP;
            next_timer = 16'(T_VPP_SETUP_CYC) + osc_cyc(T_DSET_OSC);
          end else begin
            next_state = S_VERIFY;
            next_timer = osc_cyc(T_VER_PURE_OSC);
          end
        end
      end
      S_VPPUP: begin
        if (timer == 16'h0000) begin
          next_state = S_PLOW;
          next_timer = 16'(PULSE_CYC);
        end
      end
      S_PLOW: begin
        if (timer == 16'h0000) begin
          next_state = S_PHIGH;
          next_timer = 16'(T_GAP_CYC) + osc_cyc(T_AHLD_OSC);
        end
      end
      S_PHIGH: begin
        if (timer == 16'h0000) begin
          if (pulse_cnt == 5'(N_PULSES)) begin
            next_state = S_VPPHOLD;
            next_timer = 16'(T_VPP_HOLD_CYC);
          end else begin
            next_state = S_PLOW;
            next_timer = 16'(PULSE_CYC);
          end
        end
      end
      S_VPPHOLD: begin
        if (timer == 16'h0000) begin
          next_state = S_VERIFY;
          next_timer = osc_cyc(T_VER_PROGRAM_PULSE_N_OSC);
        end
      end
      S_VERIFY: begin
        if (timer == 16'h0000) begin
          next_state = S_DONE;
        end
      end
      S_DONE: begin
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= S_IDLE;
      timer <= 16'h0000;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // ------------------------------------------------------------
  // Job capture and counters
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      job <= '0;
    end else if (cmd_valid && cmd_ready) begin
      job <= cmd;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pulse_cnt <= 5'h00;
    end else if (state == S_VPPUP) begin
      pulse_cnt <= 5'h00;
    end else if (state == S_PLOW && next_state == S_PHIGH) begin
      pulse_cnt <= pulse_cnt + 5'h01;
    end
  end

  // ------------------------------------------------------------
  // Serial mode code on the reset pin
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      device_reset_pin <= 1'b1;
      bit_cnt <= 4'h0;
    end else if (state == S_SHIFT) begin
      if (fall_tick && bit_cnt != 4'(CODE_BITS)) begin
        device_reset_pin <= 1'(mode_code(job.op) >> bit_cnt);
        bit_cnt <= bit_cnt + 4'h1;
      end else if (fall_tick) begin
        device_reset_pin <= 1'b0;
      end
    end else if (state == S_IDLE || state == S_RST) begin
      device_reset_pin <= 1'b1;
      bit_cnt <= 4'h0;
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sync_pulse_pin <= 1'b1;
      program_strobe_n <= 1'b1;
      vpp_high <= 1'b0;
      address_byte_select <= 1'b0;
      addr_port <= 8'h00;
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      sync_pulse_pin <= (next_state != S_SYNC_L);
      program_strobe_n <= (next_state != S_PLOW);
      vpp_high <= (next_state == S_VPPUP) || (next_state == S_PLOW) ||
                  (next_state == S_PHIGH) || (next_state == S_VPPHOLD);
      address_byte_select <= (next_state == S_AHI);
      if (next_state == S_AHI || next_state == S_AHOLD) begin
        addr_port <= {5'h00, job.addr[10:8]};
      end else if (next_state != S_IDLE) begin
        addr_port <= job.addr[7:0];
      end
      data_out <= job.data;
      data_oe <= is_program_pulse_n && !is_sec &&
                 ((next_state == S_VPPUP) || (next_state == S_PLOW) ||
                  (next_state == S_PHIGH) || (next_state == S_VPPHOLD));
    end
  end

  // ------------------------------------------------------------
  // Answer
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
    end else begin
      rsp_valid <= (state == S_DONE) ||
                   (cmd_valid && cmd_ready && !mode_known(cmd.op));
      if (cmd_valid && cmd_ready && !mode_known(cmd.op)) begin
        rsp <= '{err: 1'b1, sec1: 1'b0, sec2: 1'b0, data: 8'h00};
      end else if (state == S_VERIFY && timer == 16'h0000) begin
        rsp.err <= 1'b0;
        rsp.data <= data_in;
        rsp.sec1 <= data_in[SEC1_BIT];
        rsp.sec2 <= data_in[SEC2_BIT];
      end
    end
  end
endmodule : opvc_ctrl
`default_nettype wire

// file: verilog/opvc_pkg.sv
// Constants and carriers for the one-time-programmable array programmer
package opvc_pkg;
  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int OSC_DIV_DEF = 10;
  localparam int T_VPP_SETUP_US = 10;
  localparam int T_VPP_HOLD_US = 10;
  localparam int T_PULSE_US = 100;
  localparam int T_GAP_US = 10;
  localparam int T_VPP_SETUP_CYC = T_VPP_SETUP_US * CLK_MHZ;
  localparam int T_VPP_HOLD_CYC = T_VPP_HOLD_US * CLK_MHZ;
  localparam int T_PULSE_CYC = T_PULSE_US * CLK_MHZ;
  localparam int T_GAP_CYC = T_GAP_US * CLK_MHZ;
  localparam int T_RST_OSC = 24;
  localparam int T_SYNC_L_OSC = 4;
  localparam int T_SYNC_H_OSC = 8;
  localparam int T_SEL_HI_OSC = 14;
  localparam int T_AHOLD_OSC = 3;
  localparam int T_ALO_OSC = 13;
  localparam int T_ADDR_VPP_OSC = 24;
  localparam int T_DSET_OSC = 38;
  localparam int T_AHLD_OSC = 48;
  localparam int T_VER_PROGRAM_PULSE_N_OSC = 48;
  localparam int T_VER_PURE_OSC = 14;
  localparam int N_PULSES = 25;
  localparam int CODE_BITS = 10;
  localparam int SEC1_BIT = 7;
  localparam int SEC2_BIT = 6;
  // ------------------------------------------------------------
  // Mode codes
  // ------------------------------------------------------------
  localparam logic [9:0] CODE_USER = 10'h296;
  localparam logic [9:0] CODE_KEY = 10'h292;
  localparam logic [9:0] CODE_SEC1 = 10'h29a;
  localparam logic [9:0] CODE_SEC2 = 10'h298;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_PROGRAM_PULSE_N_USER = 3'h0,
    OP_VER_USER = 3'h1,
    OP_PROGRAM_PULSE_N_KEY = 3'h2,
    OP_VER_KEY = 3'h3,
    OP_PROGRAM_PULSE_N_SEC1 = 3'h4,
    OP_PROGRAM_PULSE_N_SEC2 = 3'h5,
    OP_VER_SEC = 3'h6
  } opvc_op_t;
  typedef struct packed {
    logic [2:0] op;
    logic [10:0] addr;
    logic [7:0] data;
  } opvc_cmd_t;
  typedef struct packed {
    logic err;
    logic sec1;
    logic sec2;
    logic [7:0] data;
  } opvc_rsp_t;
endpackage : opvc_pkg

// file: tb/opvc_monitor.sv
// Checker on the array programmer pins
`timescale 1ns/1ns
`default_nettype none
module opvc_monitor #(
  parameter int OSC_DIV = opvc_pkg::OSC_DIV_DEF
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire opvc_pkg::opvc_cmd_t cmd,
  input wire logic rsp_valid,
  input wire opvc_pkg::opvc_rsp_t rsp,
  input wire logic osc_clk,
  input wire logic device_reset_pin,
  input wire logic sync_pulse_pin,
  input wire logic program_strobe_n,
  input wire logic vpp_high,
  input wire logic address_byte_select,
  input wire logic [7:0] addr_port,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  import opvc_pkg::*;
  localparam int SEL_MIN = 13 * OSC_DIV;
  localparam int SYNC_MIN = 4 * OSC_DIV;
  logic [2:0] op_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Operation of the job in flight
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      op_q <= 3'h0;
    end else if (cmd_valid && cmd_ready) begin
      op_q <= cmd.op;
    end
  end
  sequence take_bad;
    cmd_valid && cmd_ready && cmd.op == 3'h7;
  endsequence
  sequence err_back;
    rsp_valid && rsp.err;
  endsequence
  strobe_vpp_a: assert property (!program_strobe_n |-> vpp_high)
    else $error("strobe low without high voltage");
  pulse_width_a: assert property
    ($fell(program_strobe_n) |-> !program_strobe_n [*8])
    else $error("strobe pulse too short");
  vpp_setup_a: assert property
    ($fell(program_strobe_n) |-> $past(vpp_high, T_VPP_SETUP_CYC))
    else $error("voltage setup too short");
  vpp_hold_a: assert property
    ($fell(vpp_high) |-> $past(program_strobe_n, T_VPP_HOLD_CYC))
    else $error("voltage hold too short");
  data_hold_a: assert property
    (!program_strobe_n && op_q < OP_PROGRAM_PULSE_N_SEC1 |->
     data_oe && $stable(data_out))
    else $error("data moved during strobe");
  addr_hold_a: assert property
    (!program_strobe_n |-> $stable(addr_port) && !address_byte_select)
    else $error("address moved during strobe");
  address_byte_select_width_a: assert property
    ($fell(address_byte_select) |-> $past(address_byte_select, SEL_MIN))
    else $error("select high too short");
  sync_low_a: assert property
    ($rose(sync_pulse_pin) |-> !$past(sync_pulse_pin, SYNC_MIN))
    else $error("sync low too short");
  port_turn_a: assert property (data_oe |-> vpp_high)
    else $error("port driven in verify");
  bad_op_a: assert property (take_bad |=> err_back)
    else $error("bad op not refused");
endmodule : opvc_monitor
`default_nettype wire

// file: tb/opvc_dev_model.sv
// Behavioural model of the programmable array device
`timescale 1ns/1ns
`default_nettype none
module opvc_dev_model (
  input wire logic osc_clk,
  input wire logic device_reset_pin,
  input wire logic sync_pulse_pin,
  input wire logic program_strobe_n,
  input wire logic vpp_high,
  input wire logic address_byte_select,
  input wire logic [7:0] addr_port,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic [7:0] data_in,
  output int pulses
);
  logic [7:0] user_mem [0:2047];
  logic [7:0] key_mem [0:15];
  logic [9:0] win = '0, code = '0;
  logic [2:0] addr_hi = 3'h0;
  logic sec1 = 1'b0, sec2 = 1'b0, burned = 1'b0;
  logic [7:0] last = 8'h00;
  logic [10:0] probe_q = '0;
  int wait_t = 0;
  wire [10:0] addr = {addr_hi, addr_port};
  wire [10:0] probe = {vpp_high, address_byte_select, data_oe, addr_port};
  wire drive = !vpp_high && !data_oe && wait_t >= (burned ? 46 : 12);
  wire [7:0] rd = (code == 10'h296) ? user_mem[addr] :
    (code == 10'h292) ? key_mem[addr[3:0]] :
    {sec1, sec2, 6'h00};
  assign data_in = drive ? rd : ~last;
  initial begin
    for (int i = 0; i < 2048; i++) user_mem[i] = 8'hff;
    for (int i = 0; i < 16; i++) key_mem[i] = 8'hff;
  end
  always @(posedge sync_pulse_pin) begin
    pulses = 0;
    burned = 1'b0;
  end
  always @(posedge osc_clk) begin
    win = {device_reset_pin, win[9:1]};
    if (device_reset_pin) code = win;
    wait_t = (probe != probe_q) ? 0 : wait_t + 1;
    probe_q = probe;
    if (drive) last = rd;
  end
  always @(negedge address_byte_select) addr_hi = addr_port[2:0];
  always @(negedge program_strobe_n) begin
    if (vpp_high) begin
      pulses++;
      burned = 1'b1;
      case (code)
        10'h296: user_mem[addr] = data_out;
        10'h292: key_mem[addr[3:0]] = data_out;
        10'h29a: sec1 = 1'b1;
        10'h298: sec2 = 1'b1;
        default: ;
      endcase
    end
  end
endmodule : opvc_dev_model
`default_nettype wire

// file: tb/tb.sv
// Testbench for the array programmer
`timescale 1ns/1ns
`default_nettype none
module tb;
  import opvc_pkg::*;
  localparam int OSC_DIV = 4;
  logic clk_sys = 1'b0, reset = 1'b1, cmd_valid = 1'b0;
  opvc_cmd_t cmd = '0;
  opvc_rsp_t rsp, got;
  logic cmd_ready, rsp_valid, osc_clk, device_reset_pin, sync_pulse_pin;
  logic program_strobe_n, vpp_high, address_byte_select, data_oe;
  logic [7:0] addr_port, data_in, data_out;
  int pulses;
  int failures = 0;
  int check_count = 0;
  opvc_ctrl #(.OSC_DIV(OSC_DIV), .PULSE_CYC(20)) i_dut (.clk_sys, .reset,
    .cmd_valid, .cmd_ready, .cmd, .rsp_valid, .rsp, .osc_clk,
    .device_reset_pin, .sync_pulse_pin, .program_strobe_n, .vpp_high,
    .address_byte_select, .addr_port, .data_in, .data_out, .data_oe);
  opvc_dev_model i_dev (.osc_clk, .device_reset_pin, .sync_pulse_pin,
    .program_strobe_n, .vpp_high, .address_byte_select, .addr_port,
    .data_out, .data_oe, .data_in, .pulses);
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic check(input string what, input logic [10:0] exp,
                       input logic [10:0] seen);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic run_job(input logic [2:0] op, input logic [10:0] a,
                         input logic [7:0] d);
    int n;
    @(negedge clk_sys);
    for (n = 0; n < 100 && cmd_ready !== 1'b1; n++) @(negedge clk_sys);
    cmd = '{op: op, addr: a, data: d};
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    for (n = 0; n < 40000 && rsp_valid !== 1'b1; n++) @(negedge clk_sys);
    check("answer", 11'h001, {10'h000, rsp_valid});
    got = rsp;
  endtask : run_job
  task automatic test_user();
    run_job(OP_PROGRAM_PULSE_N_USER, 11'h5a3, 8'h3c);
    check("program read-back", 11'h03c, {3'h0, got.data});
    check("pulse count", 11'd25, pulses[10:0]);
    run_job(OP_VER_USER, 11'h5a3, 8'h00);
    check("user verify", 11'h03c, {3'h0, got.data});
    run_job(OP_VER_USER, 11'h0a3, 8'h00);
    check("blank verify", 11'h0ff, {3'h0, got.data});
  endtask : test_user
  task automatic test_key();
    run_job(OP_PROGRAM_PULSE_N_KEY, 11'h00b, 8'ha5);
    check("key program", 11'h0a5, {3'h0, got.data});
    run_job(OP_VER_KEY, 11'h00b, 8'h00);
    check("key verify", 11'h0a5, {3'h0, got.data});
  endtask : test_key
  task automatic test_sec();
    run_job(OP_VER_SEC, 11'h000, 8'h00);
    check("bits blank", 11'h000, {9'h0, got.sec1, got.sec2});
    run_job(OP_PROGRAM_PULSE_N_SEC2, 11'h000, 8'h00);
    run_job(OP_VER_SEC, 11'h000, 8'h00);
    check("bit two", 11'h001, {9'h0, got.sec1, got.sec2});
    run_job(OP_PROGRAM_PULSE_N_SEC1, 11'h000, 8'h00);
    run_job(OP_VER_SEC, 11'h000, 8'h00);
    check("both bits", 11'h003, {9'h0, got.sec1, got.sec2});
  endtask : test_sec
  task automatic test_bad();
    run_job(3'h7, 11'h123, 8'h55);
    check("refused", 11'h001, {10'h000, got.err});
  endtask : test_bad
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    test_bad();
    test_user();
    test_key();
    test_sec();
    tally_and_finish();
  end
  initial begin
    #1900000;
    failures++;
    tally_and_finish();
  end
endmodule : tb
bind opvc_ctrl opvc_monitor #(.OSC_DIV(OSC_DIV)) i_mon (.clk_sys, .reset,
  .cmd_valid, .cmd_ready, .cmd, .rsp_valid, .rsp, .osc_clk,
  .device_reset_pin, .sync_pulse_pin, .program_strobe_n, .vpp_high,
  .address_byte_select, .addr_port, .data_in, .data_out, .data_oe);
`default_nettype wire
